/* File: pkg/gps_pkg.sv */
// package: register map and constants of the gpio steering block
package gps_pkg;
	// register word addresses (byte address = word index * 4)
	localparam logic [3:0] GPS_A_DIR_A   = 4'h0;
	localparam logic [3:0] GPS_A_PIN_A   = 4'h1;
	localparam logic [3:0] GPS_A_LAT_A   = 4'h2;
	localparam logic [3:0] GPS_A_ANS_A   = 4'h3;
	localparam logic [3:0] GPS_A_DIR_C   = 4'h4;
	localparam logic [3:0] GPS_A_PIN_C   = 4'h5;
	localparam logic [3:0] GPS_A_LAT_C   = 4'h6;
	localparam logic [3:0] GPS_A_ANS_C   = 4'h7;
	localparam logic [3:0] GPS_A_STEER   = 4'h8;
	// port widths
	localparam int          GPS_W        = 8;
	// steering field positions
	localparam int          GPS_CLC_SEL  = 1;
	localparam int          GPS_NCO_SEL  = 0;
	localparam logic [7:0]  GPS_STEER_MASK = 8'h03;
	// pin positions touched by steering
	localparam int          GPS_PA_CLC   = 2;
	localparam int          GPS_PA_NCO   = 1;
	localparam int          GPS_PC_CLC   = 5;
	localparam int          GPS_PC_NCO   = 6;
	// reset values
	localparam logic [7:0]  GPS_DIR_RST  = 8'hFF;
	localparam logic [7:0]  GPS_ANS_RST  = 8'hFF;
	localparam logic [7:0]  GPS_LAT_RST  = 8'h00;
	localparam logic [7:0]  GPS_STEER_RST = 8'h00;
	localparam logic [31:0] GPS_UNMAPPED = 32'h0000_0000;
	// bus slave states
	typedef enum logic [0:0] {GPS_IDLE, GPS_ACK} gps_bus_t;
endpackage : gps_pkg

/* File: verilog/gps_sync.sv */
// two flop synchroniser for a vector of pin levels
`timescale 1ns/1ns
module gps_sync
	import gps_pkg::*;
(
	input  wire logic             sys_clk_i,
	input  wire logic             arst_n_i,
	input  wire logic [GPS_W-1:0] async_i,
	output logic      [GPS_W-1:0] sync_o
);
	logic [GPS_W-1:0] meta_q; // first stage, read only by sync_o

	// two stages; nothing but the second stage reads the first
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_q <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule : gps_sync

/* File: verilog/gps_top.sv */
// gpio ports a and c with analog select and peripheral pin steering
`timescale 1ns/1ns
module gps_top
	import gps_pkg::*;
(
	// clock and asynchronous active low reset
	input  wire logic             sys_clk_i,
	input  wire logic             arst_n_i,
	// avalon-mm slave
	input  wire logic [3:0]       avs_address_i,
	input  wire logic             avs_read_i,
	input  wire logic             avs_write_i,
	input  wire logic [31:0]      avs_writedata_i,
	input  wire logic [3:0]       avs_byteenable_i,
	output logic      [31:0]      avs_readdata_o,
	output logic                  avs_waitrequest_o,
	// pins of port a and port c
	// in: pad levels; out: value, driver enable, input buffer enable
	input  wire logic [GPS_W-1:0] pa_in_i,
	output logic      [GPS_W-1:0] pa_out_o,
	output logic      [GPS_W-1:0] pa_oe_o,
	output logic      [GPS_W-1:0] pa_dig_en_o,
	input  wire logic [GPS_W-1:0] pc_in_i,
	output logic      [GPS_W-1:0] pc_out_o,
	output logic      [GPS_W-1:0] pc_oe_o,
	output logic      [GPS_W-1:0] pc_dig_en_o,
	// peripheral outputs, same clock
	// an enable of zero leaves the pin to its latch, a2 to pwm when pwm is enabled
	input  wire logic             logic_cell_one_output_i,
	input  wire logic             logic_cell_one_en_i,
	input  wire logic             num_ctrl_osc_one_output_i,
	input  wire logic             num_ctrl_osc_one_en_i,
	input  wire logic             pwm_output_i,
	input  wire logic             pwm_en_i
);
	// software registers
	// all eight bits of each port are implemented
	logic [GPS_W-1:0] dir_a_q;   // direction_reg a, 1 = input
	logic [GPS_W-1:0] dir_c_q;   // direction_reg c
	logic [GPS_W-1:0] lat_a_q;   // output_latch_reg a
	logic [GPS_W-1:0] lat_c_q;   // output_latch_reg c
	logic [GPS_W-1:0] ans_a_q;   // analog_select_reg a
	logic [GPS_W-1:0] ans_c_q;   // analog_select_reg c
	logic [GPS_W-1:0] steer_q;   // alternate_pin_steering
	// synchronised pin levels
	// pad levels are only ever read after the synchronisers
	logic [GPS_W-1:0] pa_sync;   // port a after two flops
	logic [GPS_W-1:0] pc_sync;   // port c after two flops
	logic [GPS_W-1:0] pa_rd;     // pin_level_reg a as read
	logic [GPS_W-1:0] pc_rd;     // pin_level_reg c as read
	// per pin ownership and override values
	// rebuilt every cycle from enables and steering bits
	logic [GPS_W-1:0] pa_own;    // peripheral owns pin
	logic [GPS_W-1:0] pa_val;    // peripheral drive value
	logic [GPS_W-1:0] pc_own;    // same for port c
	logic [GPS_W-1:0] pc_val;    // same for port c
	// next values of the registered pad outputs
	logic [GPS_W-1:0] pa_out_d;  // pad value, port a
	logic [GPS_W-1:0] pc_out_d;  // pad value, port c
	logic [GPS_W-1:0] pa_oe_d;   // driver enable, port a
	logic [GPS_W-1:0] pc_oe_d;   // driver enable, port c
	// bus
	gps_bus_t         bus_q;     // access phase
	logic             wr_go;     // write takes effect
	logic [31:0]      rdata_d;   // read word before the output flop
	logic [7:0]       wbyte;     // low byte of the write word

	// port a pin synchroniser; the pads are not on this clock,
	// so nothing reads pa_in_i before the second flop
	// costs two cycles before a pin change is readable
	gps_sync u_sync_a
	(
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.async_i   (pa_in_i),
		.sync_o    (pa_sync)
	);

	// port c pin synchroniser; same two flop path as port a
	// so both ports see a pin change after the same delay
	// no logic reads pc_in_i directly
	gps_sync u_sync_c
	(
		.sys_clk_i (sys_clk_i),
		.arst_n_i  (arst_n_i),
		.async_i   (pc_in_i),
		.sync_o    (pc_sync)
	);

	// decode: true when address hits a register word
	// shared by every write process and kept in one place
	// so a new word cannot be decoded two ways
	function automatic logic gps_hit(input logic [3:0] a, input logic [3:0] r);
		gps_hit = (a == r);
	endfunction : gps_hit

	// one wait state per access: request held, answer next edge
	// idle takes a request, ack lasts one cycle and always returns;
	// the fixed wait lets the read mux settle before data is shown,
	// traded against half the peak bus rate
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			bus_q <= GPS_IDLE;
		else
		begin
			case (bus_q)
				// wait for a read or a write
				GPS_IDLE:
					if (avs_read_i || avs_write_i)
						bus_q <= GPS_ACK;
				// answer cycle; back to idle whatever the master does
				GPS_ACK:
					bus_q <= GPS_IDLE;
				// unreachable; recover to idle
				default:
					bus_q <= GPS_IDLE;
			endcase
		end
	end

	// waitrequest low only in the ack cycle; high otherwise
	// registered so the master sees a clean level; it falls in the
	// cycle after the request is taken and rises again at once,
	// and it stays high through reset so nothing is acknowledged
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			avs_waitrequest_o <= 1'b1;
		else
			avs_waitrequest_o <= !((bus_q == GPS_IDLE) &&
				(avs_read_i || avs_write_i));
	end

	// a write lands on the edge that ends the ack cycle, while the
	// master still holds address and data
	assign wr_go = (bus_q == GPS_ACK) && avs_write_i;
	// only the low lane carries register bits
	assign wbyte = avs_writedata_i[GPS_W-1:0];

	// direction registers; steering logic never touches them
	// reset to all inputs so no pad drives before software asks
	// lane 0 must be enabled for any register write to land
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			dir_a_q <= GPS_DIR_RST;
			dir_c_q <= GPS_DIR_RST;
		end
		else if (wr_go && avs_byteenable_i[0])
		begin
			if (gps_hit(avs_address_i, GPS_A_DIR_A))
				dir_a_q <= wbyte;
			if (gps_hit(avs_address_i, GPS_A_DIR_C))
				dir_c_q <= wbyte;
		end
	end

	// latch: writes to pin or latch address both land here
	// the pin word has no storage of its own; a write to it
	// is a latch write, so read-modify-write sees latch values
	// rather than pad levels that a load may have pulled
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			lat_a_q <= GPS_LAT_RST;
			lat_c_q <= GPS_LAT_RST;
		end
		else if (wr_go && avs_byteenable_i[0])
		begin
			if (gps_hit(avs_address_i, GPS_A_LAT_A) ||
				gps_hit(avs_address_i, GPS_A_PIN_A))
				lat_a_q <= wbyte;
			if (gps_hit(avs_address_i, GPS_A_LAT_C) ||
				gps_hit(avs_address_i, GPS_A_PIN_C))
				lat_c_q <= wbyte;
		end
	end

	// analog select; resets to analog so no input buffer floats
	// a set bit turns the input buffer off and the pin reads zero
	// digital outputs are not affected by it
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ans_a_q <= GPS_ANS_RST;
			ans_c_q <= GPS_ANS_RST;
		end
		else if (wr_go && avs_byteenable_i[0])
		begin
			if (gps_hit(avs_address_i, GPS_A_ANS_A))
				ans_a_q <= wbyte;
			if (gps_hit(avs_address_i, GPS_A_ANS_C))
				ans_c_q <= wbyte;
		end
	end

	// steering register, only two bits implemented
	// upper bits are not stored and read back as zero
	// changing it moves peripherals only; directions stay put
	// a pin left behind falls back to its latch at once, or a2 to pwm when pwm is enabled
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			steer_q <= GPS_STEER_RST;
		else if (wr_go && avs_byteenable_i[0] &&
			gps_hit(avs_address_i, GPS_A_STEER))
			steer_q <= wbyte & GPS_STEER_MASK;
	end

	// analog pins read zero: input buffer is off
	// the pin word reads the synchronised pad level, not the latch,
	// so a driven pin shows what the pad really carries
	assign pa_rd = pa_sync & ~ans_a_q;
	assign pc_rd = pc_sync & ~ans_c_q;

	// ownership per pin; only the selected pin sees each peripheral
	// the alternate pin of each steered function sees nothing of it
	// and falls back to its latch, a2 to pwm first when enabled; pwm has a single home on a2
	// branches are listed top down in falling priority
	always_comb
	begin
		pa_own = '0;
		pa_val = '0;
		pc_own = '0;
		pc_val = '0;
		// port a pin 2: logic cell above pwm above latch
		if (logic_cell_one_en_i && !steer_q[GPS_CLC_SEL])
		begin
			pa_own[GPS_PA_CLC] = 1'b1;
			pa_val[GPS_PA_CLC] = logic_cell_one_output_i;
		end
		else if (pwm_en_i)
		begin
			pa_own[GPS_PA_CLC] = 1'b1;
			pa_val[GPS_PA_CLC] = pwm_output_i;
		end
		// port a pin 1 takes the oscillator when not steered away
		if (num_ctrl_osc_one_en_i && !steer_q[GPS_NCO_SEL])
		begin
			pa_own[GPS_PA_NCO] = 1'b1;
			pa_val[GPS_PA_NCO] = num_ctrl_osc_one_output_i;
		end
		// port c alternates: pin 5 for the logic cell,
		// pin 6 for the oscillator, each only when steered there
		if (logic_cell_one_en_i && steer_q[GPS_CLC_SEL])
		begin
			pc_own[GPS_PC_CLC] = 1'b1;
			pc_val[GPS_PC_CLC] = logic_cell_one_output_i;
		end
		if (num_ctrl_osc_one_en_i && steer_q[GPS_NCO_SEL])
		begin
			pc_own[GPS_PC_NCO] = 1'b1;
			pc_val[GPS_PC_NCO] = num_ctrl_osc_one_output_i;
		end
	end

	// output value: peripheral when owning, else latch
	// a peripheral output wins over the latch bit by bit
	assign pa_out_d = (pa_own & pa_val) | (~pa_own & lat_a_q);
	assign pc_out_d = (pc_own & pc_val) | (~pc_own & lat_c_q);
	// the direction bit still gates the driver even for peripherals
	// so software must clear the direction bit of a steered pin;
	// a zero in a direction bit enables the driver
	assign pa_oe_d = ~dir_a_q;
	assign pc_oe_d = ~dir_c_q;

	// registered pin drive; costs a cycle of latency to the pads
	// in reset every driver is off and every input buffer disabled,
	// so the pads float, and still do after release until software clears a direction bit
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pa_out_o    <= '0;
			pc_out_o    <= '0;
			pa_oe_o     <= '0;
			pc_oe_o     <= '0;
			pa_dig_en_o <= '0;
			pc_dig_en_o <= '0;
		end
		else
		begin
			pa_out_o    <= pa_out_d;
			pc_out_o    <= pc_out_d;
			pa_oe_o     <= pa_oe_d;
			pc_oe_o     <= pc_oe_d;
			pa_dig_en_o <= ~ans_a_q;
			pc_dig_en_o <= ~ans_c_q;
		end
	end

	// read mux, unmapped words read zero
	// upper lanes are always zero; one byte per word
	// the latch word and the pin word differ on purpose
	always_comb
	begin
		rdata_d = GPS_UNMAPPED;
		case (avs_address_i)
			GPS_A_DIR_A: rdata_d[GPS_W-1:0] = dir_a_q;
			GPS_A_PIN_A: rdata_d[GPS_W-1:0] = pa_rd;
			GPS_A_LAT_A: rdata_d[GPS_W-1:0] = lat_a_q;
			GPS_A_ANS_A: rdata_d[GPS_W-1:0] = ans_a_q;
			GPS_A_DIR_C: rdata_d[GPS_W-1:0] = dir_c_q;
			GPS_A_PIN_C: rdata_d[GPS_W-1:0] = pc_rd;
			GPS_A_LAT_C: rdata_d[GPS_W-1:0] = lat_c_q;
			GPS_A_ANS_C: rdata_d[GPS_W-1:0] = ans_c_q;
			GPS_A_STEER: rdata_d[GPS_W-1:0] = steer_q;
			default:     rdata_d = GPS_UNMAPPED;
		endcase
	end

	// read data captured as waitrequest falls
	// sampled on the edge that takes the read so it stands for the
	// whole ack cycle and holds until the next read
	// writes leave it alone
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			avs_readdata_o <= '0;
		else if (bus_q == GPS_IDLE && avs_read_i)
			avs_readdata_o <= rdata_d;
	end
endmodule : gps_top

/* File: dv/gps_pin_model.sv */
// pin model: resolves driven pins against outside levels
`timescale 1ns/1ns
module gps_pin_model
	import gps_pkg::*;
(
	input  wire logic [GPS_W-1:0] out_i,
	input  wire logic [GPS_W-1:0] oe_i,
	input  wire logic [GPS_W-1:0] ext_i,
	output logic      [GPS_W-1:0] lvl_o
);
	// a driven pin shows its driver, a released one the outside level
	assign lvl_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule : gps_pin_model

/* File: dv/gps_top_chk.sv */
// checker: bus handshake and steered pin outputs
`timescale 1ns/1ns
module gps_top_chk
	import gps_pkg::*;
(
	input wire logic             sys_clk_i,
	input wire logic             arst_n_i,
	input wire logic [3:0]       avs_address_i,
	input wire logic             avs_read_i,
	input wire logic             avs_write_i,
	input wire logic [31:0]      avs_writedata_i,
	input wire logic [3:0]       avs_byteenable_i,
	input wire logic [31:0]      avs_readdata_o,
	input wire logic             avs_waitrequest_o,
	input wire logic [GPS_W-1:0] pa_out_o,
	input wire logic [GPS_W-1:0] pc_out_o,
	input wire logic             logic_cell_one_output_i,
	input wire logic             logic_cell_one_en_i,
	input wire logic             num_ctrl_osc_one_output_i,
	input wire logic             num_ctrl_osc_one_en_i
);
	logic [1:0] sel_q; // mirror of the steering bits
	logic       rq;    // any bus request
	logic       ce;    // logic cell enabled, out of reset
	logic       ne;    // oscillator enabled, out of reset
	assign rq = avs_read_i || avs_write_i;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	// mirror follows only writes that land
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
		if (!arst_n_i)
			sel_q <= 2'h0;
		else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
			&& avs_address_i == GPS_A_STEER)
			sel_q <= avs_writedata_i[1:0];
	// a past cycle still in reset proves nothing about outputs
	always_ff @(posedge sys_clk_i)
	begin
		ce <= logic_cell_one_en_i && arst_n_i;
		ne <= num_ctrl_osc_one_en_i && arst_n_i;
	end
	a_wait_ack: assert property (rq && avs_waitrequest_o |=>
		!avs_waitrequest_o) else $error("no ack after request");
	a_wait_pulse: assert property (!avs_waitrequest_o |=>
		avs_waitrequest_o) else $error("ack longer than a cycle");
	a_no_spur: assert property (!rq && avs_waitrequest_o |=>
		avs_waitrequest_o) else $error("ack without request");
	a_rd_upper: assert property (avs_read_i && !avs_waitrequest_o |->
		avs_readdata_o[31:8] == 24'h0) else $error("upper read bits set");
	a_clc_c5: assert property (ce && $past(sel_q[1]) |->
		pc_out_o[GPS_PC_CLC] == $past(logic_cell_one_output_i))
		else $error("logic cell not on c5");
	a_clc_a2: assert property (ce && !$past(sel_q[1]) |->
		pa_out_o[GPS_PA_CLC] == $past(logic_cell_one_output_i))
		else $error("logic cell not on a2");
	a_nco_c6: assert property (ne && $past(sel_q[0]) |->
		pc_out_o[GPS_PC_NCO] == $past(num_ctrl_osc_one_output_i))
		else $error("oscillator not on c6");
	a_nco_a1: assert property (ne && !$past(sel_q[0]) |->
		pa_out_o[GPS_PA_NCO] == $past(num_ctrl_osc_one_output_i))
		else $error("oscillator not on a1");
	c_steer: cover property (sel_q == 2'h3 ##1 sel_q == 2'h0);
	c_clc_c5: cover property (ce && sel_q[1]);
	c_back: cover property (!avs_waitrequest_o ##3 !avs_waitrequest_o);
endmodule : gps_top_chk
bind gps_top gps_top_chk i_chk (.sys_clk_i, .arst_n_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
	.avs_readdata_o, .avs_waitrequest_o, .pa_out_o, .pc_out_o,
	.logic_cell_one_output_i, .logic_cell_one_en_i,
	.num_ctrl_osc_one_output_i, .num_ctrl_osc_one_en_i);

/* File: dv/testbench.sv */
// testbench: registers, pins and steering of the gpio block
`timescale 1ns/1ns
module testbench
	import gps_pkg::*;
;
	logic       clk = 0, rst_n = 0, re = 0, we = 0; // clock, bus strobes
	logic       ce = 0, ne = 0, pe = 0;             // peripheral enables
	logic       cv = 0, nv = 0, pv = 0;             // peripheral values
	logic [3:0] ad = 0;                             // word address
	logic [3:0] be = 4'hF;                          // byte lanes
	logic [31:0] wd = 0, rdd;                       // bus data
	logic       wq;                                 // waitrequest
	logic [7:0] ea = 0, ec = 0, v, v2;              // outside levels
	logic [7:0] pai, pao, pae, pad, pci, pco, pce, pcd; // pin side
	logic [7:0] q [$];                              // expected reads
	logic [7:0] rv [10] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00,
		8'h00, 8'hFF, 8'h00, 8'h00};                // reset values
	int         fails = 0, n_checks = 0, r;
	always #5 clk = ~clk;
	gps_top i_dut (.sys_clk_i(clk), .arst_n_i(rst_n), .avs_address_i(ad),
		.avs_read_i(re), .avs_write_i(we), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_readdata_o(rdd),
		.avs_waitrequest_o(wq), .pa_in_i(pai), .pa_out_o(pao),
		.pa_oe_o(pae), .pa_dig_en_o(pad), .pc_in_i(pci), .pc_out_o(pco),
		.pc_oe_o(pce), .pc_dig_en_o(pcd), .logic_cell_one_output_i(cv),
		.logic_cell_one_en_i(ce), .num_ctrl_osc_one_output_i(nv),
		.num_ctrl_osc_one_en_i(ne), .pwm_output_i(pv), .pwm_en_i(pe));
	gps_pin_model i_pa (.out_i(pao), .oe_i(pae), .ext_i(ea), .lvl_o(pai));
	gps_pin_model i_pc (.out_i(pco), .oe_i(pce), .ext_i(ec), .lvl_o(pci));
	task results;
		if (fails == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	task cmp(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("Error at %0t: pins %h want %h", $time, g, e);
		end
	endtask : cmp
	// request held until the edge that samples waitrequest low
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		ad <= a;
		wd <= {24'h0, d};
		we <= w;
		re <= !w;
		@(posedge clk);
		while (wq)
			@(posedge clk);
		we <= 0;
		re <= 0;
	endtask : bus
	task rd(input logic [3:0] a, input logic [7:0] e);
		q.push_back(e);
		bus(0, a, 8'h00);
	endtask : rd
	// read data taken at the acknowledging edge
	always @(posedge clk)
		if (re && !wq)
		begin
			n_checks++;
			if (rdd !== {24'h0, q[0]})
			begin
				fails++;
				$display("Error at %0t: read %h want %h", $time, rdd, q[0]);
			end
			void'(q.pop_front());
		end
	initial
	begin
		#50000;
		fails++;
		results;
	end
	initial
	begin
		r = $urandom(13);
		repeat (16) @(posedge clk);
		rst_n <= 1;
		ec <= 8'($urandom);
		// reset values, the unmapped word 9 included
		for (int i = 0; i < 10; i++)
			if (i % 4 != 1 || i == 9)
				rd(4'(i), rv[i]);
		cmp(pcd, 8'h00);
		bus(1, GPS_A_STEER, 8'hFF);
		rd(GPS_A_STEER, 8'h03);
		rd(GPS_A_DIR_C, 8'hFF);
		v = 8'($urandom);
		bus(1, GPS_A_LAT_A, v);
		rd(GPS_A_LAT_A, v);
		v2 = 8'($urandom);
		bus(1, GPS_A_PIN_A, v2);
		rd(GPS_A_LAT_A, v2);
		// a write without lane 0 must not land
		be <= 4'hE;
		bus(1, GPS_A_LAT_A, ~v2);
		be <= 4'hF;
		rd(GPS_A_LAT_A, v2);
		rd(4'hF, 8'h00);
		ea <= 8'($urandom);
		bus(1, GPS_A_ANS_A, 8'h0F);
		bus(1, GPS_A_ANS_C, 8'h3C);
		repeat (3) @(posedge clk);
		rd(GPS_A_PIN_A, ea & 8'hF0);
		rd(GPS_A_PIN_C, ec & 8'hC3);
		cmp(pad, 8'hF0);
		cmp(pcd, 8'hC3);
		bus(1, GPS_A_DIR_A, 8'h00);
		repeat (3) @(posedge clk);
		cmp(pae, 8'hFF);
		cmp(pao, v2);
		rd(GPS_A_PIN_A, v2 & 8'hF0);
		bus(1, GPS_A_DIR_C, 8'h00);
		ce <= 1;
		ne <= 1;
		// every steering code with fresh peripheral levels
		for (int s = 0; s < 4; s++)
		begin
			cv <= 1'($urandom);
			nv <= 1'($urandom);
			bus(1, GPS_A_STEER, 8'(s));
			repeat (2) @(posedge clk);
			cmp({4'h0, pco[6:5], pao[2:1]}, {4'h0, s[0] ? nv : 1'b0,
				s[1] ? cv : 1'b0, s[1] ? v2[2] : cv,
				s[0] ? v2[1] : nv});
		end
		rd(GPS_A_DIR_C, 8'h00);
		cmp(pce, 8'hFF);
		bus(1, GPS_A_STEER, 8'h00);
		pe <= 1;
		pv <= 1;
		cv <= 0;
		repeat (2) @(posedge clk);
		cmp({7'h0, pao[2]}, 8'h00);
		ce <= 0;
		repeat (2) @(posedge clk);
		cmp({7'h0, pao[2]}, 8'h01);
		// pins owned by peripherals still read back
		bus(1, GPS_A_ANS_A, 8'h00);
		rd(GPS_A_PIN_A, {v2[7:3], 1'h1, nv, v2[0]});
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		rd(GPS_A_LAT_A, 8'h00);
		rd(GPS_A_STEER, 8'h00);
		rd(GPS_A_DIR_A, 8'hFF);
		results;
	end
endmodule : testbench
